// [bench/ext_amp_model.sv]
// Stand-in for the external amplifier circuit at the drive outputs.
// Assumes paDrive comes straight from the block.
`timescale 1ns/100ps
module ext_amp_model
    import tx_turnaround_pkg::*;
(
    // Drive from the block.
    input  wire tx_turnaround_pkg::pa_drive_type paDrive,
    // What the amplifier sees.
    output logic                                 ampPowered,
    output logic                                 biasUsed
);
    // The switch feeds the amplifier; the pin counts only when driven.
    assign ampPowered = paDrive.supplyClosed;
    assign biasUsed = paDrive.biasPin != PIN_UNUSED;
endmodule // ext_amp_model

// [bench/tx_turnaround_pa_control_properties.sv]
// Port checker for the turnaround and amplifier control block.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module tx_turnaround_pa_control_properties
    import tx_turnaround_pkg::*;
#(parameter int ABORT_US = 5)(
    // Clock, reset and host side.
    input wire logic                              ref_clk,
    input wire logic                              rst_n,
    input wire tx_turnaround_pkg::reg_req_type    regReq,
    input wire logic [7:0]                        regRdData,
    input wire tx_turnaround_pkg::host_cmd_type   hostCmd,
    // Datapath events and outputs.
    input wire logic                              rxFrameDone,
    input wire logic                              txFrameSent,
    input wire logic                              rxPktIrq,
    input wire logic                              txSendStart,
    input wire tx_turnaround_pkg::radio_state_type radioState,
    input wire tx_turnaround_pkg::pa_drive_type   paDrive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0]  shadow_ff [16];
    logic [13:0] sinceRx_ff;
    // Copy of host writes, so outputs can be tied to their settings.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) shadow_ff <= '{default: 8'h00};
        else if (regReq.wrEn && regReq.addr[9:4] == 6'h3A)
            shadow_ff[regReq.addr[3:0]] <= regReq.data;
    end
    // Cycles since the last frame end; saturates so it never wraps.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) sinceRx_ff <= 14'h0000;
        else if (rxFrameDone) sinceRx_ff <= 14'h0001;
        else if (sinceRx_ff != 14'h0000 && sinceRx_ff < 14'h251E)
            sinceRx_ff <= sinceRx_ff + 14'h0001;
    end
    sequence s_cancel;
        radioState == TURN_S && hostCmd.valid
            && sinceRx_ff < ABORT_US * US_CYCLES;
    endsequence
    property p_cancel; s_cancel |=> radioState != TURN_S; endproperty
    a_cancel: assert property (p_cancel) else $error("cancel lost");
    property p_irq; rxPktIrq == (sinceRx_ff == 14'h251D); endproperty
    a_irq: assert property (p_irq) else $error("irq timing");
    property p_start; txSendStart |-> radioState == TX_S
        && $past(radioState) == RAMPUP_S; endproperty
    a_start: assert property (p_start) else $error("early send");
    property p_turn; $rose(radioState == TURN_S) |-> $past(rxFrameDone
        && shadow_ff[0][0] && shadow_ff[3] == PACKET_MODE); endproperty
    a_turn: assert property (p_turn) else $error("bad turn");
    property p_end; radioState == TX_S && txFrameSent
        |=> radioState inside {READY_S, RAMPDN_S}; endproperty
    a_end: assert property (p_end) else $error("bad tx end");
    property p_on; paDrive.paOn
        == $past(radioState inside {RAMPUP_S, TX_S, RAMPDN_S}); endproperty
    a_on: assert property (p_on) else $error("amp on");
    property p_supply; paDrive.supplyClosed |-> $past(shadow_ff[10][2:0])
        inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6}; endproperty
    a_supply: assert property (p_supply) else $error("switch");
    property p_high; paDrive.highPower == ($past(shadow_ff[5][5:0])
        == HIGH_PWR_BIAS && $past(shadow_ff[6][4:0]) == HIGH_PWR_BRIDGE);
    endproperty
    a_high: assert property (p_high) else $error("high power");
endmodule // tx_turnaround_pa_control_properties

bind tx_turnaround_pa_control tx_turnaround_pa_control_properties
    #(.ABORT_US(ABORT_US)) chk (.*);

// [bench/tx_turnaround_pa_control_tb.sv]
// Self-checking bench for the turnaround and amplifier control block.
// Assumes the bound checker and the amplifier model are compiled.
`timescale 1ns/100ps
module tx_turnaround_pa_control_tb;
    import tx_turnaround_pkg::*;
    logic ref_clk = 0, rst_n = 0, rxFrameDone = 0, txFrameSent = 0;
    reg_req_type     regReq = '0;
    host_cmd_type    hostCmd = '0;
    logic [7:0]      regRdData;
    logic            rxPktIrq, txSendStart, ampPowered, biasUsed;
    radio_state_type radioState;
    pa_drive_type    paDrive;
    int              miscompares = 0, checks_done = 0, n;
    always #2 ref_clk = ~ref_clk;
    // Short abort window keeps the run brief.
    tx_turnaround_pa_control #(.ABORT_US(5)) DUT (.ref_clk, .rst_n,
        .regReq, .regRdData, .hostCmd, .rxFrameDone, .txFrameSent,
        .rxPktIrq, .txSendStart, .radioState, .paDrive);
    ext_amp_model amp (.paDrive, .ampPowered, .biasUsed);
    task automatic print_verdict;
        if (miscompares == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(negedge ref_clk) regReq = '{1'b1, a, d};
        @(negedge ref_clk) regReq.wrEn = 1'b0;
    endtask
    task automatic rd(logic [9:0] a, logic [7:0] e);
        @(negedge ref_clk) regReq.addr = a;
        @(negedge ref_clk) chk("register", e, regRdData);
    endtask
    task automatic cmd(cmd_code_type c);
        @(negedge ref_clk) hostCmd = '{1'b1, c};
        @(negedge ref_clk) hostCmd.valid = 1'b0;
    endtask
    task automatic frame;
        @(negedge ref_clk) rxFrameDone = 1'b1;
        @(negedge ref_clk) rxFrameDone = 1'b0;
    endtask
    // Bounded wait; a hang counts as a mismatch and ends the run.
    task automatic waitFor(radio_state_type s);
        n = 0;
        while (radioState !== s && n < 4000) begin
            @(negedge ref_clk) n++;
        end
        if (n >= 4000) begin
            miscompares++;
            print_verdict;
        end
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        rd(OFS_BASE_DLY, 8'hC0);
        wr(OFS_EXT_MISC, 8'hA5);
        rd(OFS_EXT_MISC, 8'hA5);
        rd(10'h3B0, 8'h00);
        // Every bias mode, with the bias enable cleared and then set.
        for (int e = 0; e < 2; e++) begin
            wr(OFS_CTRL, {4'h0, e[0], 3'h0});
            for (int m = 0; m < 8; m++) begin
                wr(OFS_EXT_MISC, {4'h2, m[0], m[2:0]});
                repeat (3) @(negedge ref_clk);
                chk("switch", 8'(e && m inside {0, 1, 2, 5, 6}),
                    8'(ampPowered));
                chk("pin", 8'(e && m inside {[1:6]}), 8'(biasUsed));
                chk("pin mode", e ? 8'(32'h04321210 >> (4 * m)) & 8'h0F
                    : 8'h00, 8'(paDrive.biasPin));
                chk("source", 8'(m[0]), 8'(paDrive.refInternal));
            end
        end
        wr(OFS_BIAS_LVL, 8'h3F);
        wr(OFS_BRIDGE, 8'h15);
        repeat (3) @(negedge ref_clk);
        chk("high", 8'h01, 8'(paDrive.highPower));
        wr(OFS_BASE_DLY, 8'h02);
        wr(OFS_EXT_DLY, 8'h01);
        wr(OFS_EXT_MISC, 8'h21);
        // Turnaround with cut-off and ramp-down, external amp on auto.
        for (int s = 0; s < 2; s++) begin
            wr(OFS_CTRL, {5'h01, s[0], 1'b1});
            cmd(GO_RECEIVE);
            frame;
            waitFor(TURN_S);
            waitFor(RAMPUP_S);
            chk("delay", 8'h01, 8'(n inside {[1499:1502]}));
            waitFor(TX_S);
            chk("ramp", 8'h01, 8'(n inside {[10:12]}));
            chk("auto on", 8'h01, 8'(ampPowered));
            chk("amp", 8'h01, 8'(paDrive.paOn));
            @(negedge ref_clk) txFrameSent = 1'b1;
            @(negedge ref_clk) txFrameSent = 1'b0;
            if (s) waitFor(RAMPDN_S);
            waitFor(READY_S);
            @(negedge ref_clk) chk("auto off", 8'h00, 8'(ampPowered));
        end
        cmd(GO_RECEIVE);
        frame;
        repeat (10) @(negedge ref_clk);
        cmd(GO_IDLE);
        chk("cancel", IDLE_S, radioState);
        repeat (9500) @(negedge ref_clk);
        wr(OFS_OP_SELECT, 8'h01);
        cmd(GO_RECEIVE);
        frame;
        chk("mode", READY_S, radioState);
        print_verdict;
    end
endmodule // tx_turnaround_pa_control_tb

// [core/pa_ramp.sv]
// Power-amplifier ramp generator, linear in dB.
// Assumes each output power code step is a fixed dB step.
`timescale 1ns/100ps

module pa_ramp
    import tx_turnaround_pkg::*;
(
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Control.
    input  wire logic       rampUp,
    input  wire logic       rampDown,
    input  wire logic [3:0] target,
    input  wire logic [2:0] rateExp,
    // Status.
    output logic [3:0]      level,
    output logic            atTarget,
    output logic            atZero
);

    localparam logic [12:0] CLK_UNITS = 13'(CLK_PERIOD_PS / 100);
    localparam logic [12:0] STEP_UNIT = 13'(RAMP_UNIT_PS / 100);

    logic [12:0] acc_ff;
    logic [3:0]  level_ff;
    logic [12:0] stepLen;
    logic [12:0] nxt_acc;
    logic        doStep;

    // One code step lasts 2^rate x 2.4 ns, so ramp time scales with code.
    assign stepLen = STEP_UNIT << rateExp;
    assign nxt_acc = acc_ff + CLK_UNITS;
    assign doStep  = nxt_acc >= stepLen;

    // Fractional time carries over; faster steps than the clock saturate
    // at one code per cycle, a limit of the 4 ns period.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff   <= 13'h0000;
            level_ff <= 4'h0;
        end else if (!rampUp && !rampDown) begin
            // Idle means off, so the next ramp starts at minimum.
            acc_ff   <= 13'h0000;
            level_ff <= 4'h0;
        end else if (doStep) begin
            acc_ff <= (stepLen <= CLK_UNITS) ? 13'h0000 : nxt_acc - stepLen;
            if (rampUp && level_ff < target) begin
                level_ff <= level_ff + 4'h1;
            end else if (rampDown && level_ff != 4'h0) begin
                level_ff <= level_ff - 4'h1;
            end
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    assign level    = level_ff;
    assign atTarget = level_ff >= target;
    assign atZero   = level_ff == 4'h0;

endmodule // pa_ramp

// [core/tx_turnaround_pa_control.sv]
// Transmit turnaround, PA ramp and external PA bias control.
// Assumes the receiver flags a valid frame's last symbol, the packet
// manager flags the end of a sent frame, and the host writes registers
// and issues commands on the same 250 MHz clock.
`timescale 1ns/100ps

module tx_turnaround_pa_control
    import tx_turnaround_pkg::*;
#(
    parameter int ABORT_US = ABORT_WINDOW_US
)(
    // Clock and reset.
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    // Host register port.
    input  wire tx_turnaround_pkg::reg_req_type regReq,
    output logic [7:0]                        regRdData,
    // Host radio commands.
    input  wire tx_turnaround_pkg::host_cmd_type hostCmd,
    // Receive and transmit datapath events.
    input  wire logic                         rxFrameDone,
    input  wire logic                         txFrameSent,
    // Event and state outputs.
    output logic                              rxPktIrq,
    output logic                              txSendStart,
    output tx_turnaround_pkg::radio_state_type radioState,
    // Amplifier drive.
    output tx_turnaround_pkg::pa_drive_type   paDrive
);

    import tx_turnaround_pkg::*;

    localparam logic [9:0] IRQ_US   = 10'(IRQ_DELAY_US);
    localparam logic [9:0] ABORT_LD = 10'(ABORT_US);

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] baseDly_ff;
    logic [7:0] extDly_ff;
    logic [7:0] opSelect_ff;
    logic [2:0] rampExp_ff;
    logic [5:0] biasLevel_ff;
    logic [4:0] bridgeBias_ff;
    logic [7:0] extMisc_ff;

    radio_state_type state_ff;
    radio_state_type nxt_state;
    radio_state_type exitTo_ff;
    logic [7:0]      rdData_ff;
    logic [10:0]     delayLeft_ff;
    logic [9:0]      irqLeft_ff;
    logic [9:0]      abortLeft_ff;
    logic            irqArmed_ff;
    logic            irqPulse_ff;
    logic            sendStart_ff;
    pa_drive_type    drive_ff;
    pa_drive_type    nxt_drive;

    logic            usTick;
    logic [3:0]      rampLevel;
    logic            rampAtTarget;
    logic            rampAtZero;
    logic            autoTurn;
    logic            inTx;
    logic            extEnable;
    logic            abortCmd;
    logic [10:0]     totalDelay;
    bias_mode_type   biasMode;

    // Register writes; unmapped offsets and the status word ignore them.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff       <= CTRL_RESET;
            baseDly_ff    <= BASE_DLY_RESET;
            extDly_ff     <= EXT_DLY_RESET;
            opSelect_ff   <= OP_SEL_RESET;
            rampExp_ff    <= RAMP_EXP_RESET;
            biasLevel_ff  <= BIAS_LVL_RESET;
            bridgeBias_ff <= BRIDGE_RESET;
            extMisc_ff    <= MISC_RESET;
        end else if (regReq.wrEn) begin
            if (regReq.addr == OFS_CTRL) begin
                ctrl_ff <= regReq.data;
            end else if (regReq.addr == OFS_BASE_DLY) begin
                baseDly_ff <= regReq.data;
            end else if (regReq.addr == OFS_EXT_DLY) begin
                extDly_ff <= regReq.data;
            end else if (regReq.addr == OFS_OP_SELECT) begin
                opSelect_ff <= regReq.data;
            end else if (regReq.addr == OFS_RAMP_EXP) begin
                rampExp_ff <= regReq.data[2:0];
            end else if (regReq.addr == OFS_BIAS_LVL) begin
                biasLevel_ff <= regReq.data[5:0];
            end else if (regReq.addr == OFS_BRIDGE) begin
                bridgeBias_ff <= regReq.data[4:0];
            end else if (regReq.addr == OFS_EXT_MISC) begin
                extMisc_ff <= regReq.data;
            end
        end
    end

    // Read data is registered, so it appears one cycle after the address.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= 8'h00;
        end else if (regReq.addr == OFS_CTRL) begin
            rdData_ff <= ctrl_ff;
        end else if (regReq.addr == OFS_BASE_DLY) begin
            rdData_ff <= baseDly_ff;
        end else if (regReq.addr == OFS_EXT_DLY) begin
            rdData_ff <= extDly_ff;
        end else if (regReq.addr == OFS_OP_SELECT) begin
            rdData_ff <= opSelect_ff;
        end else if (regReq.addr == OFS_RAMP_EXP) begin
            rdData_ff <= {5'h00, rampExp_ff};
        end else if (regReq.addr == OFS_BIAS_LVL) begin
            rdData_ff <= {2'h0, biasLevel_ff};
        end else if (regReq.addr == OFS_BRIDGE) begin
            rdData_ff <= {3'h0, bridgeBias_ff};
        end else if (regReq.addr == OFS_STATUS) begin
            rdData_ff <= {1'b0, state_ff};
        end else if (regReq.addr == OFS_EXT_MISC) begin
            rdData_ff <= extMisc_ff;
        end else begin
            rdData_ff <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    us_tick u_tick (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .restart (rxFrameDone),
        .usTick  (usTick)
    );

    // Extended delay counts in four-microsecond steps.
    assign totalDelay = 11'(baseDly_ff) * 11'(BASE_STEP_US)
                      + 11'(extDly_ff) * 11'(EXT_STEP_US);

    // All three counters load at the last symbol, not at the interrupt,
    // so the host's cancel window runs in parallel with the 38 us wait.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            delayLeft_ff <= 11'h000;
            abortLeft_ff <= 10'h000;
        end else if (rxFrameDone) begin
            delayLeft_ff <= totalDelay;
            abortLeft_ff <= ABORT_LD;
        end else if (usTick) begin
            if (delayLeft_ff != 11'h000) begin
                delayLeft_ff <= delayLeft_ff - 11'h001;
            end
            if (abortLeft_ff != 10'h000) begin
                abortLeft_ff <= abortLeft_ff - 10'h001;
            end
        end
    end

    // Packet-received pulse, one cycle, 38 ticks after the last symbol.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqLeft_ff  <= 10'h000;
            irqArmed_ff <= 1'b0;
            irqPulse_ff <= 1'b0;
        end else if (rxFrameDone) begin
            irqLeft_ff  <= IRQ_US;
            irqArmed_ff <= 1'b1;
            irqPulse_ff <= 1'b0;
        end else if (usTick && irqArmed_ff) begin
            irqLeft_ff  <= irqLeft_ff - 10'h001;
            irqArmed_ff <= irqLeft_ff != 10'h001;
            irqPulse_ff <= irqLeft_ff == 10'h001;
        end else begin
            irqPulse_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Radio state machine
    // ----------------------------------------------------------------
    assign autoTurn = ctrl_ff[CTRL_TURN_BIT]
                   && opSelect_ff == PACKET_MODE;
    assign abortCmd = hostCmd.valid && abortLeft_ff != 10'h000;

    // Map a host command to the state it asks for.
    function automatic radio_state_type cmdTarget(cmd_code_type c);
        case (c)
            GO_IDLE:    cmdTarget = IDLE_S;
            GO_READY:   cmdTarget = READY_S;
            GO_RECEIVE: cmdTarget = RX_S;
            default:    cmdTarget = READY_S;
        endcase
    endfunction

    // Leaving transmit either cuts the amplifier or ramps it down first.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            IDLE_S, READY_S, RX_S: begin
                if (hostCmd.valid) begin
                    nxt_state = cmdTarget(hostCmd.code);
                end else if (state_ff == RX_S && rxFrameDone) begin
                    nxt_state = autoTurn ? TURN_S : READY_S;
                end
            end
            TURN_S: begin
                if (abortCmd) begin
                    nxt_state = cmdTarget(hostCmd.code);
                end else if (delayLeft_ff == 11'h000) begin
                    nxt_state = RAMPUP_S;
                end
            end
            RAMPUP_S, TX_S: begin
                if (hostCmd.valid || (state_ff == TX_S && txFrameSent)) begin
                    if (ctrl_ff[CTRL_RDOWN_BIT]) begin
                        nxt_state = RAMPDN_S;
                    end else if (hostCmd.valid) begin
                        nxt_state = cmdTarget(hostCmd.code);
                    end else begin
                        nxt_state = READY_S;
                    end
                end else if (state_ff == RAMPUP_S && rampAtTarget) begin
                    nxt_state = TX_S;
                end
            end
            RAMPDN_S: begin
                if (rampAtZero) begin
                    nxt_state = exitTo_ff;
                end
            end
            default: nxt_state = IDLE_S;
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= IDLE_S;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Where a ramp-down ends: a command's target, else ready.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exitTo_ff <= READY_S;
        end else if (nxt_state == RAMPDN_S && state_ff != RAMPDN_S) begin
            exitTo_ff <= hostCmd.valid ? cmdTarget(hostCmd.code)
                                       : READY_S;
        end
    end

    // Packet bits start on the cycle after the ramp reaches nominal power.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sendStart_ff <= 1'b0;
        end else begin
            sendStart_ff <= state_ff == RAMPUP_S
                         && nxt_state == TX_S;
        end
    end

    // ----------------------------------------------------------------
    // Amplifier ramp and bias
    // ----------------------------------------------------------------
    pa_ramp u_ramp (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .rampUp   (state_ff == RAMPUP_S || state_ff == TX_S),
        .rampDown (state_ff == RAMPDN_S),
        .target   (extMisc_ff[MISC_PWR_LSB +: 4]),
        .rateExp  (rampExp_ff),
        .level    (rampLevel),
        .atTarget (rampAtTarget),
        .atZero   (rampAtZero)
    );

    assign inTx     = state_ff == RAMPUP_S || state_ff == TX_S
                   || state_ff == RAMPDN_S;
    assign biasMode = bias_mode_type'(extMisc_ff[MISC_MODE_LSB +: 3]);
    // Host bit rules unless auto-enable hands control to the radio.
    assign extEnable = ctrl_ff[CTRL_AUTO_BIT] ? inTx
                     : ctrl_ff[CTRL_BIASEN_BIT];

    // Reserved mode 7 is driven safe: switch open, pin unused.
    always_comb begin
        nxt_drive              = '0;
        nxt_drive.paOn         = inTx;
        nxt_drive.paLevel      = inTx ? rampLevel : 4'h0;
        nxt_drive.highPower    = biasLevel_ff == HIGH_PWR_BIAS
                              && bridgeBias_ff == HIGH_PWR_BRIDGE;
        nxt_drive.refInternal  = extMisc_ff[MISC_SRC_BIT];
        nxt_drive.biasPin      = PIN_UNUSED;
        if (extEnable) begin
            case (biasMode)
                BIAS_SWITCH_ONLY: begin
                    nxt_drive.supplyClosed = 1'b1;
                end
                BIAS_SRC_CLOSED, BIAS_SINK_CLOSED: begin
                    nxt_drive.supplyClosed = 1'b1;
                    nxt_drive.dacEn        = 1'b1;
                    nxt_drive.biasPin      = biasMode == BIAS_SRC_CLOSED
                                           ? PIN_SOURCE : PIN_SINK;
                end
                BIAS_SRC_OPEN, BIAS_SINK_OPEN: begin
                    nxt_drive.dacEn        = 1'b1;
                    nxt_drive.biasPin      = biasMode == BIAS_SRC_OPEN
                                           ? PIN_SOURCE : PIN_SINK;
                end
                BIAS_SERVO_POS, BIAS_SERVO_NEG: begin
                    nxt_drive.supplyClosed = 1'b1;
                    nxt_drive.dacEn        = 1'b1;
                    nxt_drive.servoEn      = 1'b1;
                    nxt_drive.biasPin      = biasMode == BIAS_SERVO_POS
                                           ? PIN_SERVO_POS
                                           : PIN_SERVO_NEG;
                end
                default: nxt_drive.biasPin = PIN_UNUSED;
            endcase
        end
    end

    // Amplifier drive register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_ff <= '0;
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    assign regRdData   = rdData_ff;
    assign rxPktIrq    = irqPulse_ff;
    assign txSendStart = sendStart_ff;
    assign radioState  = state_ff;
    assign paDrive     = drive_ff;

endmodule // tx_turnaround_pa_control

// [core/tx_turnaround_pkg.sv]
// Constants, types and register map of the transmit turnaround and
// power-amplifier control block.
// Assumes one 250 MHz clock and a synchronous host register port.

package tx_turnaround_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int US_PS          = 1000000;
    localparam int US_CYCLES      = US_PS / CLK_PERIOD_PS;
    localparam int IRQ_DELAY_US   = 38;
    localparam int BASE_STEP_US   = 1;
    localparam int EXT_STEP_US    = 4;
    localparam int RAMP_UNIT_PS   = 2400;
    localparam int ABORT_WINDOW_US = 100;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [9:0] OFS_CTRL      = 10'h3A0;
    localparam logic [9:0] OFS_BASE_DLY  = 10'h3A1;
    localparam logic [9:0] OFS_EXT_DLY   = 10'h3A2;
    localparam logic [9:0] OFS_OP_SELECT = 10'h3A3;
    localparam logic [9:0] OFS_RAMP_EXP  = 10'h3A4;
    localparam logic [9:0] OFS_BIAS_LVL  = 10'h3A5;
    localparam logic [9:0] OFS_BRIDGE    = 10'h3A6;
    localparam logic [9:0] OFS_STATUS    = 10'h3A7;
    localparam logic [9:0] OFS_EXT_MISC  = 10'h3AA;

    localparam int CTRL_TURN_BIT  = 0;
    localparam int CTRL_RDOWN_BIT = 1;
    localparam int CTRL_AUTO_BIT  = 2;
    localparam int CTRL_BIASEN_BIT = 3;
    localparam int MISC_MODE_LSB  = 0;
    localparam int MISC_SRC_BIT   = 3;
    localparam int MISC_PWR_LSB   = 4;

    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] BASE_DLY_RESET = 8'hC0;
    localparam logic [7:0] EXT_DLY_RESET  = 8'h00;
    localparam logic [7:0] OP_SEL_RESET   = 8'h00;
    localparam logic [2:0] RAMP_EXP_RESET = 3'h3;
    localparam logic [5:0] BIAS_LVL_RESET = 6'h00;
    localparam logic [4:0] BRIDGE_RESET   = 5'h00;
    localparam logic [7:0] MISC_RESET     = 8'h00;

    localparam logic [7:0] PACKET_MODE    = 8'h00;
    localparam logic [5:0] HIGH_PWR_BIAS  = 6'h3F;
    localparam logic [4:0] HIGH_PWR_BRIDGE = 5'h15;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        IDLE_S   = 7'h01,
        READY_S  = 7'h02,
        RX_S     = 7'h04,
        TURN_S   = 7'h08,
        RAMPUP_S = 7'h10,
        TX_S     = 7'h20,
        RAMPDN_S = 7'h40
    } radio_state_type;

    typedef enum logic [1:0] {
        GO_IDLE    = 2'h0,
        GO_READY   = 2'h1,
        GO_RECEIVE = 2'h2
    } cmd_code_type;

    typedef enum logic [2:0] {
        BIAS_SWITCH_ONLY = 3'h0, BIAS_SRC_CLOSED = 3'h1,
        BIAS_SINK_CLOSED = 3'h2, BIAS_SRC_OPEN   = 3'h3,
        BIAS_SINK_OPEN   = 3'h4, BIAS_SERVO_POS  = 3'h5,
        BIAS_SERVO_NEG   = 3'h6, BIAS_RESERVED   = 3'h7
    } bias_mode_type;

    typedef enum logic [2:0] {
        PIN_UNUSED = 3'h0, PIN_SOURCE = 3'h1, PIN_SINK = 3'h2,
        PIN_SERVO_POS = 3'h3, PIN_SERVO_NEG = 3'h4
    } bias_pin_type;

    typedef struct packed {
        logic         valid;
        cmd_code_type code;
    } host_cmd_type;

    typedef struct packed {
        logic       wrEn;
        logic [9:0] addr;
        logic [7:0] data;
    } reg_req_type;

    typedef struct packed {
        logic         paOn;
        logic [3:0]   paLevel;
        logic         highPower;
        logic         supplyClosed;
        bias_pin_type biasPin;
        logic         dacEn;
        logic         servoEn;
        logic         refInternal;
    } pa_drive_type;

endpackage

// [core/us_tick.sv]
// Microsecond enable generator for the turnaround timers.
// Assumes the 250 MHz clock; restart realigns the phase.
`timescale 1ns/100ps

module us_tick
    import tx_turnaround_pkg::*;
(
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Control and tick.
    input  wire logic restart,
    output logic      usTick
);

    localparam logic [7:0] LAST = 8'(US_CYCLES - 1);

    logic [7:0] cnt_ff;

    // Restart lets the first tick land exactly one microsecond later.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
        end else if (restart || cnt_ff == LAST) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    assign usTick = (cnt_ff == LAST) && !restart;

endmodule // us_tick
